/* File: hw/twm_byte_count.sv */
// Count of bytes sent in the last transfer, the refused byte included.
// Assumes byte_done pulses once per byte after its acknowledge bit.
`timescale 1ns/1ps
module twm_byte_count
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic byte_done,
  output logic [twm_pkg::AMOUNT_W-1:0] amount
);
  import twm_pkg::*;

  logic [AMOUNT_W-1:0] next_amount;

  // Counts whether acknowledged or not; saturates rather than wrapping
  always_comb
  begin
    next_amount = amount;
    if (clear)
      next_amount = AMOUNT_RESET;
    else if (byte_done && amount != AMOUNT_MAX)
      next_amount = amount + 15'h0001;
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
      amount <= AMOUNT_RESET;
    else
      amount <= next_amount;
  end

  a_count_nacked: assert property (@(posedge clk) disable iff (reset)
    (byte_done && !clear && amount != AMOUNT_MAX) |=> (amount == $past(amount) + 15'h0001))
    else $error("sent byte not counted");

endmodule : twm_byte_count

/* File: hw/twm_irq_error.sv */
// Interrupt enable set/clear, event status, error source and byte count
// registers of the two-wire master, with one level interrupt output.
// Assumes a one-cycle strobe register port and event pulses on the same clock.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module twm_irq_error
(
  input wire logic clk,
  input wire logic reset,
  input twm_pkg::twm_bus_s bus,
  output logic [twm_pkg::DATA_W-1:0] rdata,
  input twm_pkg::twm_events_s events,
  input twm_pkg::twm_link_s link,
  input twm_pkg::twm_byte_s rx_in,
  input wire logic store_ready,
  output twm_pkg::twm_byte_s store,
  output logic error_event,
  output logic irq
);
  import twm_pkg::*;

  // ********************************************************************
  // Decode
  // ********************************************************************

  // Address match, used by the write and read-side-effect strobes below
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  logic wr_enable_set;
  logic wr_disable;
  logic wr_error;
  logic rd_status;

  // Write and read-side-effect strobes
  assign wr_enable_set = bus.wr && hit(bus.addr, OFF_INTERRUPT_ENABLE_SET);
  assign wr_disable = bus.wr && hit(bus.addr, OFF_INTERRUPT_DISABLE);
  assign wr_error = bus.wr && hit(bus.addr, OFF_ERROR_SOURCE);
  assign rd_status = bus.rd && hit(bus.addr, OFF_EVENT_STATUS);

  // ********************************************************************
  // Sub-blocks
  // ********************************************************************
  logic overrun;
  logic [AMOUNT_W-1:0] tx_amount;

  // Receive holding stage, flags overrun
  twm_rx_hold u_rx_hold
  (
    .clk(clk),
    .reset(reset),
    .rx_in(rx_in),
    .store_ready(store_ready),
    .store(store),
    .overrun(overrun)
  );

  // Sent-byte counter, restarted by each transmit start
  twm_byte_count u_byte_count
  (
    .clk(clk),
    .reset(reset),
    .clear(events.tx_started),
    .byte_done(link.byte_done),
    .amount(tx_amount)
  );

  // ********************************************************************
  // Interrupt enable
  // ********************************************************************
  logic [DATA_W-1:0] int_enable;
  logic [DATA_W-1:0] next_int_enable;
  logic [DATA_W-1:0] en_set;
  logic [DATA_W-1:0] en_clr;

  // One enable state reached from two addresses; only ones act
  always_comb
  begin
    en_set = wr_enable_set ? (bus.wdata & INT_FIELDS) : '0;
    en_clr = wr_disable ? (bus.wdata & INT_FIELDS) : '0;
    next_int_enable = (int_enable | en_set) & ~en_clr;
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
      int_enable <= INT_ENABLE_RESET;
    else
      int_enable <= next_int_enable;
  end

  // ********************************************************************
  // Error source
  // ********************************************************************
  logic [ERR_W-1:0] error_source;
  logic [ERR_W-1:0] next_error_source;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic next_error_event;

  // Sticky flags; a new error in the clearing cycle wins over the clear
  always_comb
  begin
    err_set = '0;
    err_set[ERR_OVERRUN] = overrun;
    err_set[ERR_ADDR_NACK] = link.addr_nack;
    err_set[ERR_DATA_NACK] = link.data_nack;
    err_clr = wr_error ? bus.wdata[ERR_W-1:0] : '0;
    next_error_source = (error_source & ~err_clr) | err_set;
    next_error_event = |(err_set & ~error_source);
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      error_source <= ERROR_SOURCE_RESET;
      error_event <= 1'b0;
    end
    else
    begin
      error_source <= next_error_source;
      error_event <= next_error_event;
    end
  end

  // ********************************************************************
  // Event status and interrupt
  // ********************************************************************
  logic [DATA_W-1:0] event_vec;
  logic [DATA_W-1:0] event_status;
  logic [DATA_W-1:0] next_event_status;
  logic next_irq;

  // Place the event pulses on their enable bit positions
  always_comb
  begin
    event_vec = '0;
    event_vec[BIT_EVENT_A] = events.event_a;
    event_vec[BIT_ERROR] = error_event;
    event_vec[BIT_SUSPENDED] = events.suspended;
    event_vec[BIT_RX_STARTED] = events.rx_started;
    event_vec[BIT_TX_STARTED] = events.tx_started;
    event_vec[BIT_LAST_RX] = events.last_rx;
    event_vec[BIT_LAST_TX] = events.last_tx;
  end

  // Each status bit is sticky; a read clears, a new event in that cycle stays
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1)
    begin : g_status
      assign next_event_status[gi] = (event_status[gi] && !rd_status) || event_vec[gi];
    end
  endgenerate

  // Level interrupt computed from next values so it tracks the flops exactly
  assign next_irq = |(next_event_status & next_int_enable);

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      event_status <= EVENT_STATUS_RESET;
      irq <= 1'b0;
    end
    else
    begin
      event_status <= next_event_status;
      irq <= next_irq;
    end
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  logic [DATA_W-1:0] next_rdata;

  // Data stand only in the cycle after the read strobe, zero otherwise
  always_comb
  begin
    next_rdata = '0;
    if (bus.rd)
    begin
      case (bus.addr)
        OFF_INTERRUPT_ENABLE_SET: next_rdata = int_enable;
        OFF_INTERRUPT_DISABLE: next_rdata = int_enable;
        OFF_ERROR_SOURCE: next_rdata = {{(DATA_W-ERR_W){1'b0}}, error_source};
        OFF_EVENT_STATUS: next_rdata = event_status;
        OFF_TX_AMOUNT: next_rdata = {{(DATA_W-AMOUNT_W){1'b0}}, tx_amount};
        default: next_rdata = '0;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

  // ********************************************************************
  // Checks
  // ********************************************************************

  a_stop_disable: assert property (@(posedge clk) disable iff (reset)
    (wr_disable && bus.wdata[BIT_EVENT_A]) |=> !int_enable[BIT_EVENT_A])
    else $error("event_a enable not cleared");

  a_error_readback: assert property (@(posedge clk) disable iff (reset)
    (bus.rd && hit(bus.addr, OFF_INTERRUPT_DISABLE)) |=> (rdata[BIT_ERROR] == $past(int_enable[BIT_ERROR])))
    else $error("error enable read back wrong");

  a_disable_others: assert property (@(posedge clk) disable iff (reset)
    wr_disable |=> ((int_enable & ~$past(bus.wdata)) == ($past(int_enable) & ~$past(bus.wdata))))
    else $error("disable write touched other enables");

  a_start_disable: assert property (@(posedge clk) disable iff (reset)
    (wr_disable && bus.wdata[BIT_RX_STARTED] && bus.wdata[BIT_TX_STARTED])
      |=> (!int_enable[BIT_RX_STARTED] && !int_enable[BIT_TX_STARTED]))
    else $error("started enables not cleared");

  a_last_disable: assert property (@(posedge clk) disable iff (reset)
    (wr_disable && bus.wdata[BIT_LAST_RX] && bus.wdata[BIT_LAST_TX])
      |=> (!int_enable[BIT_LAST_RX] && !int_enable[BIT_LAST_TX]))
    else $error("last-byte enables not cleared");

  a_shared_enable: assert property (@(posedge clk) disable iff (reset)
    (wr_enable_set && bus.wdata[BIT_SUSPENDED]) ##1 (bus.rd && hit(bus.addr, OFF_INTERRUPT_DISABLE))
      |=> rdata[BIT_SUSPENDED])
    else $error("enable set not seen through disable register");

  a_overrun_flag: assert property (@(posedge clk) disable iff (reset)
    overrun |=> error_source[ERR_OVERRUN])
    else $error("overrun not flagged");

  a_addr_nack: assert property (@(posedge clk) disable iff (reset)
    link.addr_nack |=> error_source[ERR_ADDR_NACK] ##1 error_source[ERR_ADDR_NACK] || $past(wr_error))
    else $error("address nack not flagged");

  a_data_nack_clear: assert property (@(posedge clk) disable iff (reset)
    (wr_error && bus.wdata[ERR_DATA_NACK] && !link.data_nack) |=> !error_source[ERR_DATA_NACK])
    else $error("data nack flag not cleared");

  a_zero_keeps: assert property (@(posedge clk) disable iff (reset)
    (wr_error && !bus.wdata[ERR_ADDR_NACK] && error_source[ERR_ADDR_NACK]) |=> error_source[ERR_ADDR_NACK])
    else $error("zero write cleared a flag");

  a_error_event: assert property (@(posedge clk) disable iff (reset)
    (link.data_nack && !error_source[ERR_DATA_NACK]) |=> error_event ##1 event_status[BIT_ERROR])
    else $error("new error flag raised no error event");

  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    irq == |(event_status & int_enable))
    else $error("interrupt level disagrees with status and enable");

endmodule : twm_irq_error

/* File: hw/twm_rx_hold.sv */
// Receive holding stage between the byte shifter and the receive memory.
// Assumes the shifter pulses valid once per byte, on the system clock.
`timescale 1ns/1ps
module twm_rx_hold
(
  input wire logic clk,
  input wire logic reset,
  input twm_pkg::twm_byte_s rx_in,
  input wire logic store_ready,
  output twm_pkg::twm_byte_s store,
  output logic overrun
);
  import twm_pkg::*;

  twm_byte_s next_store;
  logic next_overrun;

  // A waiting byte is replaced, never queued: an old byte is lost on overrun
  always_comb
  begin
    next_overrun = rx_in.valid && store.valid && !store_ready;
    next_store.valid = rx_in.valid || (store.valid && !store_ready);
    next_store.data = rx_in.valid ? rx_in.data : store.data;
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      store <= '0;
      overrun <= 1'b0;
    end
    else
    begin
      store <= next_store;
      overrun <= next_overrun;
    end
  end

  a_overrun_discard: assert property (@(posedge clk) disable iff (reset)
    (rx_in.valid && store.valid && !store_ready) |=> (store.valid && overrun && store.data == $past(rx_in.data)))
    else $error("old byte kept after overrun");

endmodule : twm_rx_hold

/* File: shared/twm_pkg.sv */
// Shared constants, register map and carrier types for the two-wire master
// interrupt-disable and error-source block.
// Assumes one system clock and a synchronous active-high reset everywhere.
package twm_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 12'h10C;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_ENABLE_SET = 12'h304;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_DISABLE = 12'h308;
  localparam logic [ADDR_W-1:0] OFF_ERROR_SOURCE = 12'h4C4;
  localparam logic [ADDR_W-1:0] OFF_TX_AMOUNT = 12'h54C;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_EVENT_A = 1;
  localparam int BIT_ERROR = 9;
  localparam int BIT_SUSPENDED = 18;
  localparam int BIT_RX_STARTED = 19;
  localparam int BIT_TX_STARTED = 20;
  localparam int BIT_LAST_RX = 23;
  localparam int BIT_LAST_TX = 24;
  localparam logic [DATA_W-1:0] INT_FIELDS = 32'h019C0202;
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_ADDR_NACK = 1;
  localparam int ERR_DATA_NACK = 2;
  localparam int ERR_W = 3;
  localparam int AMOUNT_W = 15;
  localparam logic [AMOUNT_W-1:0] AMOUNT_MAX = 15'h7FFF;

  // ********************************************************************
  // Values after reset
  // ********************************************************************
  localparam logic [DATA_W-1:0] INT_ENABLE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] EVENT_STATUS_RESET = 32'h00000000;
  localparam logic [ERR_W-1:0] ERROR_SOURCE_RESET = 3'h0;
  localparam logic [AMOUNT_W-1:0] AMOUNT_RESET = 15'h0000;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } twm_bus_s;

  typedef struct packed {
    logic event_a;
    logic suspended;
    logic rx_started;
    logic tx_started;
    logic last_rx;
    logic last_tx;
  } twm_events_s;

  typedef struct packed {
    logic addr_nack;
    logic data_nack;
    logic byte_done;
  } twm_link_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } twm_byte_s;

endpackage : twm_pkg

/* File: verif/twm_irq_error_test.sv */
// Self-checking bench for the interrupt-disable and error-source block.
// Assumes the shared package and the far-side model in this folder.
`timescale 1ns/1ps
module twm_irq_error_test;
  import twm_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] clr;
    logic [DATA_W-1:0] exp;
  } twm_row_s;

  // ********************************************************************
  // Signals and table
  // ********************************************************************
  localparam logic [3:0] C_ADDR_NACK = 4'h8;
  localparam logic [3:0] C_DATA_NACK = 4'h4;
  localparam logic [3:0] C_ACK = 4'h2;
  localparam logic [3:0] C_RX = 4'h1;
  localparam twm_events_s EV_STOP = 6'h20;
  localparam twm_events_s EV_TX = 6'h04;
  // Each field cleared alone, then a zero write and a bit outside the fields
  localparam twm_row_s ROWS [9] = '{
    '{32'h00000002, 32'h019C0200}, '{32'h00000200, 32'h019C0002}, '{32'h00040000, 32'h01980202},
    '{32'h00080000, 32'h01940202}, '{32'h00100000, 32'h018C0202}, '{32'h00800000, 32'h011C0202},
    '{32'h01000000, 32'h009C0202}, '{32'h00000000, 32'h019C0202}, '{32'h00000001, 32'h019C0202}};
  logic clk;
  logic reset;
  twm_bus_s bus;
  logic [DATA_W-1:0] rdata;
  twm_events_s events;
  twm_link_s link;
  twm_byte_s rx_in;
  logic store_ready;
  twm_byte_s store;
  logic error_event;
  logic irq;
  logic [3:0] cmd;
  logic [7:0] byte_val;
  int n_fail;
  int num_checks;
  int n_err_ev = 0;

  twm_irq_error dut_u
  (
    .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .events(events), .link(link),
    .rx_in(rx_in), .store_ready(store_ready), .store(store), .error_event(error_event), .irq(irq)
  );

  twm_slave_model slave_u
  (
    .clk(clk), .cmd(cmd), .byte_val(byte_val), .link(link), .rx_in(rx_in)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Error event is a single-cycle pulse, so count it where it happens
  always @(posedge clk)
  begin
    if (error_event === 1'b1)
      n_err_ev <= n_err_ev + 1;
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic chk(input string nm, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask : done

  // One-cycle strobes; a gap cycle between calls keeps one assignment per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(nm, rdata, e);
  endtask : rd

  task automatic fire(input logic [3:0] c, input twm_events_s e, input logic [7:0] b);
    @(posedge clk);
    cmd <= c;
    events <= e;
    byte_val <= b;
    @(posedge clk);
    cmd <= 4'h0;
    events <= 6'h00;
  endtask : fire

  task automatic wait_irq(input logic v);
    // Look just after each edge so the registered level has settled
    #1;
    for (int i = 0; i < 20 && irq !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irq", {31'h0, irq}, {31'h0, v});
    if (irq !== v)
      finish_test();
  endtask : wait_irq

  // ********************************************************************
  // Sequence
  // ********************************************************************
  initial
  begin
    reset = 1'b1;
    bus = '0;
    events = 6'h00;
    cmd = 4'h0;
    byte_val = 8'h00;
    store_ready = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(OFF_INTERRUPT_DISABLE, 32'h00000000, "disable reset value");
    rd(OFF_ERROR_SOURCE, 32'h00000000, "error source reset value");
    rd(12'h400, 32'h00000000, "unmapped read");
    done("reset values");
    foreach (ROWS[i])
    begin
      wr(OFF_INTERRUPT_ENABLE_SET, 32'hFFFFFFFF);
      wr(OFF_INTERRUPT_DISABLE, ROWS[i].clr);
      rd(OFF_INTERRUPT_DISABLE, ROWS[i].exp, "disable readback");
      rd(OFF_INTERRUPT_ENABLE_SET, ROWS[i].exp, "enable readback");
    end
    done("disable table");
    // Count restarts on transfer start; the refused byte is counted too
    fire(4'h0, EV_TX, 8'h00);
    fire(C_ACK, 6'h00, 8'h00);
    fire(C_DATA_NACK, 6'h00, 8'h00);
    repeat (3) @(posedge clk);
    rd(OFF_TX_AMOUNT, 32'h00000002, "sent count");
    rd(OFF_ERROR_SOURCE, 32'h00000004, "data nack flag");
    fire(C_ADDR_NACK, 6'h00, 8'h00);
    repeat (3) @(posedge clk);
    rd(OFF_ERROR_SOURCE, 32'h00000006, "both nack flags");
    wr(OFF_ERROR_SOURCE, 32'h00000000);
    rd(OFF_ERROR_SOURCE, 32'h00000006, "flags after zero write");
    wr(OFF_ERROR_SOURCE, 32'h00000002);
    rd(OFF_ERROR_SOURCE, 32'h00000004, "address nack cleared");
    wr(OFF_ERROR_SOURCE, 32'h00000004);
    rd(OFF_ERROR_SOURCE, 32'h00000000, "data nack cleared");
    chk("error event pulses", 32'(n_err_ev), 32'h00000002);
    done("nack flags");
    // Second byte lands while memory stalls: the first one is dropped
    fire(C_RX, 6'h00, 8'hA1);
    fire(C_RX, 6'h00, 8'hA2);
    repeat (4) @(posedge clk);
    chk("held byte", {23'h0, store}, {23'h0, 1'b1, 8'hA2});
    rd(OFF_ERROR_SOURCE, 32'h00000001, "overrun flag");
    chk("error event pulses", 32'(n_err_ev), 32'h00000003);
    @(posedge clk);
    store_ready <= 1'b1;
    @(posedge clk);
    store_ready <= 1'b0;
    @(posedge clk);
    chk("store drained", {31'h0, store.valid}, 32'h00000000);
    wr(OFF_ERROR_SOURCE, 32'h00000001);
    rd(OFF_ERROR_SOURCE, 32'h00000000, "overrun cleared");
    done("overrun");
    // Interrupt raised, read away, then masked while its status stays set
    wr(OFF_INTERRUPT_DISABLE, 32'hFFFFFFFF);
    rd(OFF_EVENT_STATUS, 32'h00100200, "event status");
    chk("irq all disabled", {31'h0, irq}, 32'h00000000);
    wr(OFF_INTERRUPT_ENABLE_SET, 32'h00000200);
    fire(C_DATA_NACK, 6'h00, 8'h00);
    wait_irq(1'b1);
    rd(OFF_EVENT_STATUS, 32'h00000200, "error status");
    wait_irq(1'b0);
    wr(OFF_INTERRUPT_ENABLE_SET, 32'h00000002);
    fire(4'h0, EV_STOP, 8'h00);
    wait_irq(1'b1);
    wr(OFF_INTERRUPT_DISABLE, 32'h00000002);
    wait_irq(1'b0);
    rd(OFF_EVENT_STATUS, 32'h00000002, "masked status");
    done("interrupt");
    // Set then read through the disable address with no gap between strobes
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: OFF_INTERRUPT_ENABLE_SET, wdata: 32'h00040000};
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: OFF_INTERRUPT_DISABLE, wdata: 32'h00000000};
    @(posedge clk);
    bus <= '0;
    #1;
    chk("set then read", rdata, 32'h00040200);
    @(posedge clk);
    #1;
    chk("read data gone", rdata, 32'h00000000);
    done("back to back");
    // Reset in mid-run with state present
    wr(OFF_INTERRUPT_ENABLE_SET, 32'hFFFFFFFF);
    fire(C_ADDR_NACK, 6'h00, 8'h00);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rd(OFF_INTERRUPT_DISABLE, 32'h00000000, "disable after reset");
    rd(OFF_ERROR_SOURCE, 32'h00000000, "flags after reset");
    chk("irq after reset", {31'h0, irq}, 32'h00000000);
    done("mid-run reset");
    finish_test();
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    $display("Error run limit expected finish seen hang");
    n_fail++;
    finish_test();
  end
endmodule : twm_irq_error_test

/* File: verif/twm_slave_model.sv */
// Far-side model: two-wire slaves that acknowledge, refuse and send bytes.
// Assumes one-cycle command pulses from the bench on the system clock.
`timescale 1ns/1ps
module twm_slave_model
(
  input wire logic clk,
  input wire logic [3:0] cmd,
  input wire logic [7:0] byte_val,
  output twm_pkg::twm_link_s link,
  output twm_pkg::twm_byte_s rx_in
);
  import twm_pkg::*;

  // Registered answers; idle data is inverted so a stale byte never passes as fresh
  always_ff @(posedge clk)
  begin
    link.addr_nack <= cmd[3];
    link.data_nack <= cmd[2];
    link.byte_done <= cmd[2] | cmd[1]; // Refused byte still ends its ack bit
    rx_in.valid <= cmd[0];
    rx_in.data <= cmd[0] ? byte_val : ~byte_val;
  end
endmodule : twm_slave_model
